// [windowed_watchdog_timer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_timer_tb;
    localparam int TD = 2;
    logic        clk, rstn, halt, stop, bit_op, fv, dv, psel, pen, pwr;
    logic [6:0]  opt;
    logic [15:0] fa, da, mtop;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, wdt_rst, er;
    int          failures, checks_done, pulses, m;

    wwdt_top #(.TICK_DIV(TD)) i_wwdt_top (
        .SYS_CLK_I(clk), .RESETN_I(rstn), .OPTION_BYTE_I(opt),
        .HALT_MODE_I(halt), .STOP_MODE_I(stop), .BIT_OP_I(bit_op),
        .FETCH_VALID_I(fv), .FETCH_ADDR_I(fa), .DATA_VALID_I(dv),
        .DATA_ADDR_I(da), .MEM_TOP_I(mtop), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .WDT_RESET_O(wdt_rst));

    // clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // count internal reset pulses
    always @(posedge clk) begin
        if (wdt_rst === 1'b1) pulses <= pulses + 1;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [17:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            failures++;
            tally_and_finish();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask

    // reset with a new option byte {win, en, sel, lock}
    task automatic rst(input logic [6:0] o);
        @(posedge clk);
        rstn <= 1'b0;
        opt <= o;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask

    // key write, then count pulses that follow
    task automatic key_wr(input logic [7:0] k, input int exp);
        int p;
        p = pulses;
        apb(1'b1, wwdt_pkg::KEY_ADDR, {24'h000000, k});
        repeat (3) @(posedge clk);
        check(pulses - p, exp);
    endtask

    task automatic bad_key_and_flag();
        rst({2'h3, 1'h1, 3'h7, 1'h1});
        apb(1'b0, wwdt_pkg::KEY_ADDR, 32'h00000000);
        check(rd, 32'h0000009A);
        key_wr(8'h55, 1);
        apb(1'b0, wwdt_pkg::RSTF_ADDR, 32'h00000000);
        check(rd[4], 1'b1);
        apb(1'b1, wwdt_pkg::RSTF_ADDR, 32'h00000010);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        check(rd < 32'h00000010, 1'b1);
        apb(1'b0, 18'h00010, 32'h00000000);
        check({er, rd[30:0]}, 32'h80000000);
        m = pulses;
        bit_op <= 1'b1;
        key_wr(8'hAC, 1);
        bit_op <= 1'b0;
    endtask

    task automatic window_rules();
        rst({2'h0, 1'h1, 3'h1, 1'h1});
        key_wr(8'hAC, 0);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        check(rd < 32'h00000008, 1'b1);
        repeat (3200) @(posedge clk);
        key_wr(8'hAC, 0);
        key_wr(8'hAC, 1);
        key_wr(8'hAC, 0);
        apb(1'b0, wwdt_pkg::KEY_ADDR, 32'h00000000);
        check(rd, 32'h0000009A);
    endtask

    task automatic overflow_time();
        int n;
        rst({2'h3, 1'h1, 3'h0, 1'h1}); // shortest overflow, full window
        m = pulses;
        for (n = 0; n < 3000 && pulses == m; n++) @(posedge clk);
        check(n >= TD * 1022 && n <= TD * 1026 + 4, 1'b1);
    endtask

    task automatic pause_and_defer();
        logic [31:0] a;
        rst({2'h3, 1'h1, 3'h7, 1'h0});
        repeat (40) @(posedge clk);
        halt <= 1'b1;
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        a = rd;
        repeat (60) @(posedge clk);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        check(rd, a);
        halt <= 1'b0;
        apb(1'b1, wwdt_pkg::OSC_ADDR, 32'h00000002);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        a = rd;
        repeat (60) @(posedge clk);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        check(rd, a);
        apb(1'b1, wwdt_pkg::OSC_ADDR, 32'h00000000);
        m = pulses;
        stop <= 1'b1;
        key_wr(8'h33, 0);
        stop <= 1'b0;
        repeat (4) @(posedge clk);
        check(pulses - m, 1);
    endtask

    // one-cycle fetch or data access, then count pulses
    task automatic access(input logic f, input logic [15:0] a,
                          input int exp);
        m = pulses;
        fv <= f;
        dv <= ~f;
        fa <= a;
        da <= a;
        @(posedge clk);
        fv <= 1'b0;
        dv <= 1'b0;
        repeat (3) @(posedge clk);
        check(pulses - m, exp);
    endtask

    task automatic area_checks();
        rst({2'h3, 1'h1, 3'h7, 1'h1});
        access(1'b1, 16'h8000, 1);
        access(1'b1, 16'h7FFF, 0);
        access(1'b0, 16'h9000, 1);
        access(1'b0, 16'hFB00, 0);
        halt <= 1'b1;
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        m = rd;
        repeat (20) @(posedge clk);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        check(rd > m, 1'b1);
        halt <= 1'b0;
        rst({2'h3, 1'h0, 3'h7, 1'h1});
        apb(1'b0, wwdt_pkg::KEY_ADDR, 32'h00000000);
        check(rd, 32'h0000001A);
        access(1'b1, 16'h8000, 0);
        apb(1'b0, wwdt_pkg::CNT_ADDR, 32'h00000000);
        check(rd, 32'h00000000);
    endtask

    // bound on the whole run
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        {rstn, halt, stop, bit_op, fv, dv, psel, pen, pwr} = 9'h000;
        failures = 0;
        checks_done = 0;
        pulses = 0;
        m = 0;
        opt = 7'h00;
        fa = 16'h0000;
        da = 16'h0000;
        mtop = 16'h7FFF;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        bad_key_and_flag();
        window_rules();
        overflow_time();
        pause_and_defer();
        area_checks();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [wwdt_pkg.sv]
`default_nettype none
package wwdt_pkg;
    // system clock and nominal slow oscillator rate
    localparam int CLK_HZ      = 50_000_000;
    localparam int SLOW_OSC_HZ = 33_000;
    localparam int TICK_DIV    = CLK_HZ / SLOW_OSC_HZ;
    localparam int TICK_W      = 11;
    // register indices; byte address is four times the index
    localparam logic [15:0] KEY_IDX  = 16'hFF99;
    localparam logic [15:0] OSC_IDX  = 16'hFFA1;
    localparam logic [15:0] RSTF_IDX = 16'hFFA8;
    localparam logic [15:0] CNT_IDX  = 16'hFFB0;
    localparam int          ADDR_W   = 18;
    localparam logic [17:0] KEY_ADDR  = {KEY_IDX, 2'b00};
    localparam logic [17:0] OSC_ADDR  = {OSC_IDX, 2'b00};
    localparam logic [17:0] RSTF_ADDR = {RSTF_IDX, 2'b00};
    localparam logic [17:0] CNT_ADDR  = {CNT_IDX, 2'b00};
    // service key values
    localparam logic [7:0] KEY_SERVICE  = 8'hAC;
    localparam logic [7:0] KEY_RST_EN   = 8'h9A;
    localparam logic [7:0] KEY_RST_DIS  = 8'h1A;
    // option byte field positions
    localparam int OPT_LOCK    = 0;
    localparam int OPT_OVF_LO  = 1;
    localparam int OPT_EN      = 4;
    localparam int OPT_WIN_LO  = 5;
    // register bit positions
    localparam int OSC_HALT_BIT = 1;
    localparam int RSTF_WDT_BIT = 4;
    // counter sizing and overflow base exponent
    localparam int CNT_W       = 17;
    localparam int OVF_BASE    = 10;
    // data area always allowed for data accesses
    localparam logic [15:0] SAFE_LO = 16'hFB00;
    localparam logic [15:0] SAFE_HI = 16'hFFFF;
endpackage
`default_nettype wire

// [wwdt_top.sv]
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - counter advances only on slow oscillator ticks, not CPU clock.
// - reaching selected overflow without service issues internal reset.
// - writing ACH at a permitted time clears counter and restarts.
// - writing other than ACH resets; deferred until source clock runs.
// - bit manipulation on service register resets; deferred if clock stopped.
// - after first service, writes in closed window reset, even ACH.
// - first service after reset release clears regardless of window.
// - service register reads return its reset value, never written data.
// - reset value is 9AH when enabled, 1AH when disabled.
// - enable option gates counting and illegal access detection.
// - option bits 3..1 select overflow 2^10 to 2^17 ticks.
// - option bits 6..5 select open window 25, 50, 75, 100 percent.
// - lock option 0 pauses count in HALT and STOP, keeping value.
// - lock 0 and slow oscillator halted stops count without clearing.
// - enabled, fetch outside configured memory area resets.
// - enabled, data access outside area resets, except FB00H to FFFFH.
// - any watchdog reset sets reset-cause flag bit 4.
// - counting continues during flash self-programming.
// - overflow after service may deviate by up to two slow periods.
// - valid service on last count before overflow still clears.
module wwdt_top #(
    parameter int TICK_DIV = wwdt_pkg::TICK_DIV
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        RESETN_I,
    input  wire logic [6:0]  OPTION_BYTE_I,
    input  wire logic        HALT_MODE_I,
    input  wire logic        STOP_MODE_I,
    input  wire logic        BIT_OP_I,
    input  wire logic        FETCH_VALID_I,
    input  wire logic [15:0] FETCH_ADDR_I,
    input  wire logic        DATA_VALID_I,
    input  wire logic [15:0] DATA_ADDR_I,
    input  wire logic [15:0] MEM_TOP_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [17:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic             WDT_RESET_O
);
    localparam int CW = wwdt_pkg::CNT_W;

    // last count before overflow for a select code
    function automatic logic [CW-1:0] ovf_last(input logic [2:0] sel);
        logic [CW:0] len;
        len = (CW+1)'(1) << (wwdt_pkg::OVF_BASE + int'(sel));
        return CW'(len - (CW+1)'(1));
    endfunction

    // count below which the window is closed
    function automatic logic [CW-1:0] close_lim(input logic [2:0] sel,
                                                input logic [1:0] win);
        logic [CW-1:0] q;
        q = CW'(1) << (wwdt_pkg::OVF_BASE - 2 + int'(sel));
        return CW'(q * (CW'(3) - CW'(win)));
    endfunction

    logic [6:0]          opt_r;
    logic [CW-1:0]       cnt_r;
    logic [wwdt_pkg::TICK_W-1:0] div_r;
    logic                tick;
    logic                first_done_r;
    logic                pend_r;
    logic                osc_halt_r;
    logic                wdt_flag_r;
    logic                rst_r;
    logic                pready_r;
    logic                pslverr_r;
    logic [31:0]         prdata_r;
    logic                en;
    logic                lock;
    logic [2:0]          ovf_sel;
    logic [1:0]          win_sel;
    logic                src_stop;
    logic                paused;
    logic                acc;
    logic                wr;
    logic                key_acc;
    logic                key_wr;
    logic                bad_key;
    logic                closed_wr;
    logic                svc_ok;
    logic                key_err;
    logic                ovf;
    logic                fetch_err;
    logic                data_err;
    logic                fire;
    logic                setup;
    logic                mapped;

    // option fields
    assign en      = opt_r[wwdt_pkg::OPT_EN];
    assign lock    = opt_r[wwdt_pkg::OPT_LOCK];
    assign ovf_sel = opt_r[wwdt_pkg::OPT_OVF_LO +: 3];
    assign win_sel = opt_r[wwdt_pkg::OPT_WIN_LO +: 2];

    // slow clock stopped, and counting paused
    assign src_stop = !lock && (STOP_MODE_I || osc_halt_r);
    assign paused   = !lock && (HALT_MODE_I || src_stop);

    // bus phases
    assign setup   = PSEL_I && !PENABLE_I;
    assign acc     = PSEL_I && PENABLE_I && pready_r;
    assign wr      = acc && PWRITE_I;
    assign key_acc = acc && (PADDR_I == wwdt_pkg::KEY_ADDR);
    assign key_wr  = key_acc && PWRITE_I;

    // service write classification
    assign bad_key   = key_wr && !BIT_OP_I &&
                       (PWDATA_I[7:0] != wwdt_pkg::KEY_SERVICE);
    assign closed_wr = key_wr && first_done_r &&
                       (cnt_r < close_lim(ovf_sel, win_sel));
    assign svc_ok    = key_wr && !BIT_OP_I && !bad_key &&
                       !closed_wr;
    assign key_err   = bad_key || (key_acc && BIT_OP_I) ||
                       closed_wr;

    // overflow only on a tick without service in the same cycle
    assign ovf = en && tick && !paused && !svc_ok &&
                 (cnt_r == ovf_last(ovf_sel));

    // illegal fetch and data access detection
    assign fetch_err = en && FETCH_VALID_I &&
                       (FETCH_ADDR_I > MEM_TOP_I);
    assign data_err  = en && DATA_VALID_I &&
                       (DATA_ADDR_I > MEM_TOP_I) &&
                       !(DATA_ADDR_I >= wwdt_pkg::SAFE_LO &&
                         DATA_ADDR_I <= wwdt_pkg::SAFE_HI);

    // key errors wait while the source clock is stopped
    assign fire = ovf || fetch_err || data_err ||
                  (!src_stop && (key_err || pend_r));

    // option byte captured while reset is held
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            opt_r <= OPTION_BYTE_I;
        end
    end

    // free running divider gives one-cycle slow oscillator tick
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + wwdt_pkg::TICK_W'(1);
        end
    end
    assign tick = (div_r == wwdt_pkg::TICK_W'(TICK_DIV - 1));

    // watchdog counter; only a cleared enable option or a pause stops it
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I || fire) begin
            cnt_r <= '0;
        end else if (svc_ok) begin
            cnt_r <= '0;
        end else if (en && tick && !paused) begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    // first service tracking
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I || fire) begin
            first_done_r <= 1'b0;
        end else if (svc_ok) begin
            first_done_r <= 1'b1;
        end
    end

    // pending key error while source clock is stopped
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I || fire) begin
            pend_r <= 1'b0;
        end else if (key_err) begin
            pend_r <= 1'b1;
        end
    end

    // internal reset pulse
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            rst_r <= 1'b0;
        end else begin
            rst_r <= fire;
        end
    end

    // reset cause flag: set wins over software clear
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            wdt_flag_r <= 1'b0;
        end else if (fire) begin
            wdt_flag_r <= 1'b1;
        end else if (wr && PADDR_I == wwdt_pkg::RSTF_ADDR &&
                     PWDATA_I[wwdt_pkg::RSTF_WDT_BIT]) begin
            wdt_flag_r <= 1'b0;
        end
    end

    // oscillator mode register, slow oscillator halt bit
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            osc_halt_r <= 1'b0;
        end else if (wr && PADDR_I == wwdt_pkg::OSC_ADDR) begin
            osc_halt_r <= PWDATA_I[wwdt_pkg::OSC_HALT_BIT];
        end
    end

    // address decode for reads and errors
    always_comb begin
        mapped = 1'b1;
        case (PADDR_I)
            wwdt_pkg::KEY_ADDR,
            wwdt_pkg::OSC_ADDR,
            wwdt_pkg::RSTF_ADDR,
            wwdt_pkg::CNT_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // apb answer: one access cycle, no wait states
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESETN_I) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r  <= '0;
            if (setup && !PWRITE_I) begin
                case (PADDR_I)
                    wwdt_pkg::KEY_ADDR: prdata_r[7:0] <= en ?
                        wwdt_pkg::KEY_RST_EN :
                        wwdt_pkg::KEY_RST_DIS;
                    wwdt_pkg::OSC_ADDR:
                        prdata_r[wwdt_pkg::OSC_HALT_BIT] <= osc_halt_r;
                    wwdt_pkg::RSTF_ADDR:
                        prdata_r[wwdt_pkg::RSTF_WDT_BIT] <= wdt_flag_r;
                    wwdt_pkg::CNT_ADDR: prdata_r[CW-1:0] <= cnt_r;
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign PRDATA_O    = prdata_r;
    assign PREADY_O    = pready_r;
    assign PSLVERR_O   = pslverr_r;
    assign WDT_RESET_O = rst_r;

    // checks run on the system clock and rest while reset is held
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESETN_I);

    // overflow, service, window, read, pause, access and flag checks
    ovf_reset_a: assert property (
        en && tick && !paused && !svc_ok &&
        cnt_r == ovf_last(ovf_sel) |=> WDT_RESET_O && cnt_r == '0)
        else $error("overflow did not reset");

    svc_clear_a: assert property (
        svc_ok && !fire |=> cnt_r == '0 && !WDT_RESET_O)
        else $error("service did not clear counter");

    bad_key_a: assert property (
        bad_key && !src_stop |=> WDT_RESET_O)
        else $error("wrong key did not reset");

    deferred_a: assert property (
        pend_r && src_stop && !fire ##1 !src_stop |=> WDT_RESET_O)
        else $error("deferred reset lost");

    bit_op_a: assert property (
        key_acc && BIT_OP_I && !src_stop |=> WDT_RESET_O)
        else $error("bit access did not reset");

    closed_a: assert property (
        key_wr && first_done_r && !src_stop &&
        cnt_r < close_lim(ovf_sel, win_sel) |=> WDT_RESET_O)
        else $error("closed window write did not reset");

    first_svc_a: assert property (
        key_wr && !first_done_r && !BIT_OP_I &&
        PWDATA_I[7:0] == wwdt_pkg::KEY_SERVICE && !fire
        |=> first_done_r && cnt_r == '0)
        else $error("first service not accepted");

    key_read_a: assert property (
        setup && !PWRITE_I && PADDR_I == wwdt_pkg::KEY_ADDR
        |=> PREADY_O && PRDATA_O[7:0] == (en ? 8'h9A : 8'h1A))
        else $error("service register read wrong");

    disabled_a: assert property (
        !en |-> cnt_r == '0)
        else $error("disabled watchdog counted");

    hold_a: assert property (
        paused && !svc_ok && !fire |=> $stable(cnt_r))
        else $error("paused counter moved");

    fetch_a: assert property (
        en && FETCH_VALID_I && FETCH_ADDR_I > MEM_TOP_I |=> WDT_RESET_O)
        else $error("illegal fetch not reset");

    safe_data_a: assert property (
        DATA_VALID_I && DATA_ADDR_I >= 16'hFB00 && !FETCH_VALID_I &&
        !key_err && !pend_r && !ovf |=> !WDT_RESET_O)
        else $error("safe area access reset");

    flag_a: assert property (
        WDT_RESET_O |-> wdt_flag_r)
        else $error("reset cause flag not set");

    // counter timing and pause checks
    tick_only_a: assert property (
        !tick && !svc_ok && !fire |=> $stable(cnt_r))
        else $error("counter moved without slow tick");

    cnt_range_a: assert property (
        en |-> cnt_r <= ovf_last(ovf_sel))
        else $error("counter passed overflow count");

    lock_runs_a: assert property (
        en && lock && (HALT_MODE_I || STOP_MODE_I) && tick && !svc_ok &&
        !fire |=> cnt_r != $past(cnt_r))
        else $error("locked counter stopped in low power");

    osc_stop_a: assert property (
        !lock && osc_halt_r && !svc_ok && !fire |=> $stable(cnt_r))
        else $error("counter moved with slow oscillator halted");

    // service key, reset effect and detection checks
    open_svc_a: assert property (
        key_wr && first_done_r && !BIT_OP_I &&
        PWDATA_I[7:0] == wwdt_pkg::KEY_SERVICE &&
        cnt_r >= close_lim(ovf_sel, win_sel) && !fire
        |=> cnt_r == '0 && !WDT_RESET_O)
        else $error("open window service refused");

    pend_wait_a: assert property (
        key_err && src_stop && !fire |=> pend_r && !WDT_RESET_O)
        else $error("key error not held while clock stopped");

    rst_clears_a: assert property (
        WDT_RESET_O |-> cnt_r == '0 && !first_done_r)
        else $error("internal reset left state behind");

    flag_set_a: assert property (
        fire |=> wdt_flag_r)
        else $error("reset cause flag missed");

    detect_off_a: assert property (
        !en && !key_err && !pend_r |=> !WDT_RESET_O)
        else $error("disabled watchdog raised reset");

    fetch_ok_a: assert property (
        en && FETCH_VALID_I && FETCH_ADDR_I <= MEM_TOP_I &&
        !DATA_VALID_I && !key_err && !pend_r && !ovf |=> !WDT_RESET_O)
        else $error("legal fetch raised reset");

    // coverage of the main scenarios
    svc_c: cover property (svc_ok && first_done_r);
    ovf_c: cover property (ovf);
    defer_c: cover property (pend_r && src_stop ##1 !src_stop);
    closed_c: cover property (closed_wr);
    halt_c: cover property (en && lock && HALT_MODE_I && tick);

endmodule
`default_nettype wire
